// >>> design/tmr8_defines.svh
// register offsets, field positions and reset values of the 8-bit timer
`ifndef TMR8_DEFINES_SVH
`define TMR8_DEFINES_SVH

`define TMR8_ADDR_W 12
`define TMR8_OFS_CTRL_A 12'h000
`define TMR8_OFS_CTRL_B 12'h004
`define TMR8_OFS_COUNT 12'h008
`define TMR8_OFS_CMP_A 12'h00c
`define TMR8_OFS_CMP_B 12'h010
`define TMR8_OFS_FLAGS 12'h014
`define TMR8_OFS_MASK 12'h018

`define TMR8_CA_WGM0 0
`define TMR8_CA_WGM1 1
`define TMR8_CA_COMB_LSB 4
`define TMR8_CA_COMA_LSB 6
`define TMR8_CB_CS_LSB 0
`define TMR8_CB_WGM2 3
`define TMR8_CB_FORCE_B 6
`define TMR8_CB_FORCE_A 7

`define TMR8_FL_OVF 0
`define TMR8_FL_MATCH_A 1
`define TMR8_FL_MATCH_B 2

`define TMR8_RST_BYTE 8'h00
`define TMR8_MAX 8'hff
`define TMR8_BOTTOM 8'h00

`endif

// >>> design/tmr8_pkg.sv
// types shared by the 8-bit timer and its bench
package tmr8_pkg;
    // compare pin bundle: level and active-low output enable per channel
    typedef struct packed {
        logic [1:0] level;
        logic [1:0] oeN;
    } tmr8_pin_type;

    // count direction of the dual-slope modes
    typedef enum logic {
        TMR8_UP,
        TMR8_DOWN
    } tmr8_dir_type;
endpackage

// >>> design/tmr8_counter_compare.sv
// 8-bit timer/counter with two compare channels behind an APB slave
//
// What this block does
// R1: clock select zero gives no timer tick; counter stays stopped.
// R2: counter is 8-bit up/down; each tick clears, increments or decrements it.
// R3: software can read and write the counter at any time.
// R4: software counter write beats any same-cycle clear or count.
// R5: three-bit waveform mode: two low bits in control A, high bit in B.
// R6: counter equal to compare value sets that match flag on the next tick.
// R7: enabled flag raises interrupt request; service acknowledge clears it.
// R8: writing one to a flag bit clears it; zero leaves it.
// R9: PWM modes double-buffer compare values, loaded at top or bottom.
// R10: compare accesses reach the buffer in PWM modes, else the active value.
// R11: force strobe in non-PWM modes acts on output only, no flag, no clear.
// R12: any counter write blocks all compare matches on the next tick.
// R13: output action field is unbuffered; applies from the next match.
// R14: reset clears each compare output state bit.
// R15: nonzero output action routes compare output to pin; direction unchanged.
// R16: output action zero leaves the compare output state on a match.
// R17: output action never changes the counting sequence.
// R18: mode zero only increments, never clears, wraps 0xFF to 0x00.
// R19: mode zero sets overflow when counter becomes zero; cleared by service acknowledge or by writing one.
// R20: mode zero accepts a counter write at any moment.
// R21: changing modes keeps the compare output state bits.
// R22: software should set compare output before enabling pin as output.
// R23: mode two clears the counter on match with compare value A.
// R24: modes three and seven are fast PWM, top 0xFF or compare A.
// R25: modes one and five are phase correct PWM, top 0xFF or compare A.
// R26: the timer tick is a one-cycle enable in the system clock domain.
//
// The implementer's own choices: the register offsets and the APB register port.
`timescale 1ns/1ps
`include "tmr8_defines.svh"

module tmr8_counter_compare #(
    parameter int CNT_W = 8
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [`TMR8_ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic tickIn,
    input wire logic [2:0] intAck,
    output logic [2:0] irqReq,
    input wire logic [1:0] portData,
    input wire logic [1:0] portDir,
    output tmr8_pkg::tmr8_pin_type pins
);

    // the compare and counter datapath is built for one byte only
    if (CNT_W != 8) begin : g_bad_width
        $error("tmr8_counter_compare supports CNT_W of 8 only");
    end

    logic [7:0] timerControlAReg;
    logic [3:0] timerControlBReg;
    logic [7:0] counterValueReg;
    logic [7:0] counterValueNext;
    tmr8_pkg::tmr8_dir_type dirReg;
    tmr8_pkg::tmr8_dir_type dirNext;
    logic overflowFlagReg;
    logic [2:0] maskReg;
    logic blockReg;
    logic preadyReg;
    logic pslverrReg;
    logic [31:0] prdataReg;
    logic [2:0] irqReg;
    tmr8_pkg::tmr8_pin_type pinsReg;
    logic [7:0] readMux;
    logic addrHit;
    logic [7:0] cmpAct [2];
    logic [7:0] cmpBuf [2];
    logic [1:0] matchFlagVec;
    logic [1:0] ocVec;
    logic [1:0] comVec [2];
    logic ovfEvent;
    logic bufLoad;
    logic bottomEvent;

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    // bus qualifiers: one wait state, write lands at the completing edge
    wire access = psel && penable;
    wire xferDone = access && preadyReg;
    wire wr = xferDone && pwrite;
    wire wrCount = wr && (paddr == `TMR8_OFS_COUNT);
    wire wrCtrlA = wr && (paddr == `TMR8_OFS_CTRL_A);
    wire wrCtrlB = wr && (paddr == `TMR8_OFS_CTRL_B);
    wire wrFlags = wr && (paddr == `TMR8_OFS_FLAGS);
    wire wrMask = wr && (paddr == `TMR8_OFS_MASK);

    // mode field assembled from both control registers
    // R5: mode bits split
    wire [2:0] waveMode = {timerControlBReg[`TMR8_CB_WGM2], timerControlAReg[`TMR8_CA_WGM1],
        timerControlAReg[`TMR8_CA_WGM0]};
    wire [2:0] clockSelect = timerControlBReg[`TMR8_CB_CS_LSB +: 3];
    wire pwmMode = waveMode[0];
    wire fastMode = (waveMode == 3'd3) || (waveMode == 3'd7);
    wire [7:0] topValue = waveMode[2] ? cmpAct[0] : `TMR8_MAX;

    // R1: gated tick
    // R26: single-cycle enable
    wire tick = tickIn && (clockSelect != 3'd0);

    // control registers; force strobes are not stored
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            timerControlAReg <= `TMR8_RST_BYTE;
            timerControlBReg <= 4'h0;
        end else begin
            if (wrCtrlA) begin
                timerControlAReg <= pwdata[7:0];
            end
            if (wrCtrlB) begin
                timerControlBReg <= pwdata[3:0];
            end
        end
    end

    // counting sequence by mode, then the cpu write on top
    always_comb begin
        counterValueNext = counterValueReg;
        dirNext = (waveMode[0] && !waveMode[1]) ? dirReg : tmr8_pkg::TMR8_UP;
        ovfEvent = 1'b0;
        bufLoad = 1'b0;
        bottomEvent = 1'b0;
        if (tick) begin
            unique case (waveMode)
                // R25: dual slope
                3'd1, 3'd5: begin
                    dirNext = dirReg;
                    if (dirReg == tmr8_pkg::TMR8_UP) begin
                        if (counterValueReg == topValue) begin
                            dirNext = tmr8_pkg::TMR8_DOWN;
                            counterValueNext = counterValueReg - 8'h01;
                            bufLoad = 1'b1;
                        end else begin
                            counterValueNext = counterValueReg + 8'h01;
                        end
                    end else if (counterValueReg == `TMR8_BOTTOM) begin
                        dirNext = tmr8_pkg::TMR8_UP;
                        counterValueNext = counterValueReg + 8'h01;
                        ovfEvent = 1'b1;
                    end else begin
                        counterValueNext = counterValueReg - 8'h01;
                    end
                end
                // R24: single slope
                3'd3, 3'd7: begin
                    if (counterValueReg == topValue) begin
                        counterValueNext = `TMR8_BOTTOM;
                        ovfEvent = 1'b1;
                        bufLoad = 1'b1;
                        bottomEvent = 1'b1;
                    end else begin
                        counterValueNext = counterValueReg + 8'h01;
                    end
                end
                // R23: clear on compare A
                3'd2: begin
                    ovfEvent = (counterValueReg == `TMR8_MAX);
                    if (counterValueReg == cmpAct[0]) begin
                        counterValueNext = `TMR8_BOTTOM;
                    end else begin
                        counterValueNext = counterValueReg + 8'h01;
                    end
                end
                // R18: plain increment
                default: begin
                    counterValueNext = counterValueReg + 8'h01;
                    ovfEvent = (counterValueReg == `TMR8_MAX);
                end
            endcase
        end
        // R4: write has priority
        // R20: write at any moment
        if (wrCount) begin
            counterValueNext = pwdata[7:0];
            ovfEvent = 1'b0;
        end
    end

    // R2: counter and direction
    // R17: sequence set by mode only
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            counterValueReg <= `TMR8_RST_BYTE;
            dirReg <= tmr8_pkg::TMR8_UP;
        end else begin
            counterValueReg <= counterValueNext;
            dirReg <= dirNext;
        end
    end

    // R12: block matches for one tick after a counter write
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            blockReg <= 1'b0;
        end else if (wrCount) begin
            blockReg <= 1'b1;
        end else if (tick) begin
            blockReg <= 1'b0;
        end
    end

    // R19: overflow flag, set beats clear
    // R7: service acknowledge clears
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            overflowFlagReg <= 1'b0;
        end else if (ovfEvent) begin
            overflowFlagReg <= 1'b1;
        end else if (intAck[0] || (wrFlags && pwdata[`TMR8_FL_OVF])) begin
            overflowFlagReg <= 1'b0;
        end
    end

    // per-channel compare value, flag and output state
    for (genvar c = 0; c < 2; c++) begin : g_ch
        localparam logic [`TMR8_ADDR_W-1:0] OFS = (c == 0) ? `TMR8_OFS_CMP_A : `TMR8_OFS_CMP_B;
        localparam int COM_LSB = (c == 0) ? `TMR8_CA_COMA_LSB : `TMR8_CA_COMB_LSB;
        localparam int FORCE_BIT = (c == 0) ? `TMR8_CB_FORCE_A : `TMR8_CB_FORCE_B;
        localparam int FLAG_BIT = (c == 0) ? `TMR8_FL_MATCH_A : `TMR8_FL_MATCH_B;
        logic [7:0] actReg;
        logic [7:0] bufReg;
        logic flagReg;
        logic ocReg;
        logic ocNext;
        // R13: action field read live, no buffering
        wire [1:0] com = timerControlAReg[COM_LSB +: 2];
        wire wrCmp = wr && (paddr == OFS);
        wire match = tick && !blockReg && (counterValueReg == actReg);
        wire force_ = wrCtrlB && pwdata[FORCE_BIT] && !pwmMode;

        // R9: buffer loads active at top or bottom
        // R10: direct access outside pwm
        always_ff @(posedge clk_sys or posedge rst) begin
            if (rst) begin
                bufReg <= `TMR8_RST_BYTE;
                actReg <= `TMR8_RST_BYTE;
            end else begin
                if (wrCmp) begin
                    bufReg <= pwdata[7:0];
                end
                if (wrCmp && !pwmMode) begin
                    actReg <= pwdata[7:0];
                end else if (bufLoad && pwmMode) begin
                    actReg <= bufReg;
                end
            end
        end

        // R6: flag set on tick
        // R8: write one clears
        always_ff @(posedge clk_sys or posedge rst) begin
            if (rst) begin
                flagReg <= 1'b0;
            end else if (match) begin
                flagReg <= 1'b1;
            end else if (intAck[FLAG_BIT] || (wrFlags && pwdata[FLAG_BIT])) begin
                flagReg <= 1'b0;
            end
        end

        // output action per mode family
        // R16: action zero keeps state
        always_comb begin
            ocNext = ocReg;
            if (!pwmMode) begin
                // R11: force acts like a match on the output only
                if (match || force_) begin
                    unique case (com)
                        2'd1: ocNext = !ocReg;
                        2'd2: ocNext = 1'b0;
                        2'd3: ocNext = 1'b1;
                        default: ocNext = ocReg;
                    endcase
                end
            end else if (fastMode) begin
                if (match) begin
                    if (com == 2'd2) begin
                        ocNext = 1'b0;
                    end else if (com == 2'd3) begin
                        ocNext = 1'b1;
                    end else if (com == 2'd1 && c == 0 && waveMode[2]) begin
                        ocNext = !ocReg;
                    end
                end
                if (bottomEvent && com[1]) begin
                    ocNext = !com[0];
                end
            end else if (match && com[1]) begin
                ocNext = (dirReg == tmr8_pkg::TMR8_DOWN) ^ com[0];
            end
        end

        // R14: cleared on reset
        // R21: untouched by mode change
        always_ff @(posedge clk_sys or posedge rst) begin
            if (rst) begin
                ocReg <= 1'b0;
            end else begin
                ocReg <= ocNext;
            end
        end

        assign cmpAct[c] = actReg;
        assign cmpBuf[c] = bufReg;
        assign matchFlagVec[c] = flagReg;
        assign ocVec[c] = ocReg;
        assign comVec[c] = com;
    end

    // interrupt mask register
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            maskReg <= 3'h0;
        end else if (wrMask) begin
            maskReg <= pwdata[2:0];
        end
    end

    // R7: masked requests
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            irqReg <= 3'h0;
        end else begin
            irqReg <= {matchFlagVec, overflowFlagReg} & maskReg;
        end
    end

    // R15: pin override, direction from port
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            pinsReg <= '{level: 2'h0, oeN: 2'h3};
        end else begin
            for (int i = 0; i < 2; i++) begin
                pinsReg.level[i] <= (comVec[i] != 2'd0) ? ocVec[i] : portData[i];
                pinsReg.oeN[i] <= !portDir[i];
            end
        end
    end

    // R3: read mux, compare view depends on buffering
    always_comb begin
        readMux = 8'h00;
        addrHit = 1'b1;
        unique case (paddr)
            `TMR8_OFS_CTRL_A: readMux = timerControlAReg;
            `TMR8_OFS_CTRL_B: readMux = {4'h0, timerControlBReg};
            `TMR8_OFS_COUNT: readMux = counterValueReg;
            `TMR8_OFS_CMP_A: readMux = pwmMode ? cmpBuf[0] : cmpAct[0];
            `TMR8_OFS_CMP_B: readMux = pwmMode ? cmpBuf[1] : cmpAct[1];
            `TMR8_OFS_FLAGS: readMux = {5'h00, matchFlagVec, overflowFlagReg};
            `TMR8_OFS_MASK: readMux = {5'h00, maskReg};
            default: addrHit = 1'b0;
        endcase
    end

    // apb answer: ready one cycle into the access phase
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            preadyReg <= 1'b0;
            pslverrReg <= 1'b0;
            prdataReg <= 32'h0;
        end else begin
            preadyReg <= access && !preadyReg;
            if (access && !preadyReg) begin
                pslverrReg <= !addrHit;
                prdataReg <= {24'h0, readMux};
            end else begin
                pslverrReg <= 1'b0;
            end
        end
    end

    assign prdata = prdataReg;
    assign pready = preadyReg;
    assign pslverr = pslverrReg;
    assign irqReq = irqReg;
    assign pins = pinsReg;

    // checks kept next to the logic they guard
    property p_stopped;
        (clockSelect == 3'd0) && !wrCount |=> $stable(counterValueReg);
    endproperty
    a_stopped: assert property (p_stopped) else $error("counter moved with no clock selected"); // R1

    property p_write_wins;
        wrCount |=> counterValueReg == $past(pwdata[7:0]);
    endproperty
    a_write_wins: assert property (p_write_wins) else $error("counter write lost"); // R4

    property p_normal_inc;
        tick && (waveMode == 3'd0) && !wrCount |=> counterValueReg == $past(counterValueReg) + 8'h01;
    endproperty
    a_normal_inc: assert property (p_normal_inc) else $error("normal mode did not increment"); // R18

    property p_normal_ovf;
        tick && (waveMode == 3'd0) && !wrCount && (counterValueReg == 8'hff)
            |=> overflowFlagReg && (counterValueReg == 8'h00);
    endproperty
    a_normal_ovf: assert property (p_normal_ovf) else $error("overflow flag not set at wrap"); // R19

    sequence s_count_write;
        wrCount;
    endsequence
    sequence s_blocked_tick;
        blockReg && tick && !g_ch[0].flagReg;
    endsequence
    property p_block_arm;
        s_count_write |=> blockReg;
    endproperty
    a_block_arm: assert property (p_block_arm) else $error("counter write did not arm blocking"); // R12
    property p_block;
        s_blocked_tick |=> !g_ch[0].flagReg;
    endproperty
    a_block: assert property (p_block) else $error("match not blocked after counter write"); // R12

    property p_match_flag;
        tick && !blockReg && (counterValueReg == cmpAct[1]) |=> matchFlagVec[1];
    endproperty
    a_match_flag: assert property (p_match_flag) else $error("match flag b not set"); // R6

    property p_zero_keeps;
        wrFlags && !pwdata[`TMR8_FL_MATCH_A] && !intAck[1] && matchFlagVec[0] |=> matchFlagVec[0];
    endproperty
    a_zero_keeps: assert property (p_zero_keeps) else $error("writing zero cleared a flag"); // R8

    property p_ctc_clear;
        tick && (waveMode == 3'd2) && !wrCount && (counterValueReg == cmpAct[0]) |=> counterValueReg == 8'h00;
    endproperty
    a_ctc_clear: assert property (p_ctc_clear) else $error("ctc did not clear on compare a"); // R23

    property p_force_set;
        wrCtrlB && pwdata[`TMR8_CB_FORCE_A] && !pwmMode && (comVec[0] == 2'd3) && !matchFlagVec[0] && !tick
            |=> ocVec[0] && !matchFlagVec[0];
    endproperty
    a_force_set: assert property (p_force_set) else $error("force did not set output alone"); // R11

    property p_pin_route;
        (comVec[1] != 2'd0) |=> pins.level[1] == $past(ocVec[1]) && pins.oeN[1] == !$past(portDir[1]);
    endproperty
    a_pin_route: assert property (p_pin_route) else $error("compare output not on pin"); // R15

endmodule

// >>> dv/tmr8_tb.sv
// self-checking bench of the 8-bit timer with two compare channels
`timescale 1ns/1ps
`include "tmr8_defines.svh"

module tb;
    logic clk_sys, rst, psel, penable, pwrite, pready, pslverr, tickIn, err;
    logic [`TMR8_ADDR_W-1:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [2:0] intAck, irqReq;
    logic [1:0] portData, portDir;
    tmr8_pkg::tmr8_pin_type pins;
    int errors, num_checks, mCnt, mDir, mActA, mActB, mBufA, mBufB, mFlags, mBlk, mMask, mOcA;
    logic [7:0] mCtlA, mCtlB;
    int modes[6] = '{0, 2, 3, 7, 1, 5};

    // unit under test
    tmr8_counter_compare #(.CNT_W(8)) i_tmr8_counter_compare (.clk_sys(clk_sys), .rst(rst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .tickIn(tickIn), .intAck(intAck), .irqReq(irqReq), .portData(portData),
        .portDir(portDir), .pins(pins));

    // system clock
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            errors++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    function automatic int mode();
        return {mCtlB[3], mCtlA[1:0]};
    endfunction

    function automatic void mdlClear();
        mCnt = 0;
        mDir = 0;
        mActA = 0;
        mActB = 0;
        mBufA = 0;
        mBufB = 0;
        mFlags = 0;
        mBlk = 0;
        mMask = 0;
        mOcA = 0;
        mCtlA = 8'h00;
        mCtlB = 8'h00;
    endfunction

    // register writes of the model
    function automatic void mdlWrite(input logic [11:0] a, input logic [7:0] d);
        case (a)
            `TMR8_OFS_CTRL_A: mCtlA = d;
            `TMR8_OFS_CTRL_B: begin
                mCtlB = d;
                if (d[7] && mode() % 2 == 0 && mCtlA[7:6] != 2'h0) begin
                    mOcA = (mCtlA[7:6] == 2'h1) ? 1 - mOcA : mCtlA[7:6] - 2;
                end
            end
            `TMR8_OFS_COUNT: begin
                mCnt = d;
                mBlk = 1;
            end
            `TMR8_OFS_CMP_A: begin
                mBufA = d;
                if (mode() % 2 == 0) mActA = d;
            end
            `TMR8_OFS_CMP_B: begin
                mBufB = d;
                if (mode() % 2 == 0) mActB = d;
            end
            `TMR8_OFS_FLAGS: mFlags = mFlags & ~d;
            `TMR8_OFS_MASK: mMask = d[2:0];
            default: ;
        endcase
    endfunction

    function automatic logic [31:0] mdlRead(input logic [11:0] a);
        case (a)
            `TMR8_OFS_CTRL_A: return {24'h000000, mCtlA};
            `TMR8_OFS_CTRL_B: return {24'h000000, mCtlB & 8'h3f};
            `TMR8_OFS_COUNT: return mCnt;
            `TMR8_OFS_CMP_A: return (mode() % 2) ? mBufA : mActA;
            `TMR8_OFS_CMP_B: return (mode() % 2) ? mBufB : mActB;
            `TMR8_OFS_FLAGS: return mFlags;
            `TMR8_OFS_MASK: return mMask;
            default: return 32'h00000000;
        endcase
    endfunction

    // one timer tick of the model
    function automatic void mdlTick();
        int top;
        int md;
        md = mode();
        top = (md == 2 || md == 5 || md == 7) ? mActA : 255;
        if (mCtlB[2:0] == 3'h0) return;
        if (mBlk == 0 && mCnt == mActA) mFlags |= 2;
        if (mBlk == 0 && mCnt == mActB) mFlags |= 4;
        mBlk = 0;
        if (md == 3 || md == 7) begin
            if (mCnt == top) begin
                mCnt = 0;
                mFlags |= 1;
                mActA = mBufA;
                mActB = mBufB;
            end else begin
                mCnt++;
            end
        end else if (md == 1 || md == 5) begin
            if (mDir == 0 && mCnt == top) begin
                mDir = 1;
                mActA = mBufA;
                mActB = mBufB;
            end else if (mDir == 1 && mCnt == 0) begin
                mDir = 0;
                mFlags |= 1;
            end
            mCnt = mDir ? mCnt - 1 : mCnt + 1;
        end else begin
            if (mCnt == 255) mFlags |= 1;
            mCnt = (md == 2 && mCnt == mActA) ? 0 : (mCnt + 1) % 256;
        end
    endfunction

    // apb transfer, optional tick held through it
    task automatic apb(input logic wr, input logic [11:0] a, input logic [7:0] d, input bit holdTick);
        int n;
        n = 0;
        @(posedge clk_sys);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= {24'h000000, d};
        if (holdTick) tickIn <= 1'b1;
        @(posedge clk_sys);
        penable <= 1'b1;
        do begin
            @(posedge clk_sys);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) begin
            errors++;
            report_and_stop();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        tickIn <= 1'b0;
    endtask

    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        apb(1'b1, a, d, 1'b0);
        mdlWrite(a, d);
    endtask

    task automatic rdchk(input logic [11:0] a);
        apb(1'b0, a, 8'h00, 1'b0);
        chk(rd, mdlRead(a));
        chk({31'h0, err}, {31'h0, a > `TMR8_OFS_MASK});
    endtask

    task automatic tick();
        @(posedge clk_sys);
        tickIn <= 1'b1;
        @(posedge clk_sys);
        tickIn <= 1'b0;
        mdlTick();
    endtask

    task automatic doReset();
        @(posedge clk_sys);
        rst <= 1'b1;
        repeat (2) @(posedge clk_sys);
        rst <= 1'b0;
        mdlClear();
    endtask

    task automatic pinA(input logic [31:0] exp);
        repeat (4) @(posedge clk_sys);
        chk({31'h0, pins.level[0]}, exp);
    endtask

    // random run of one waveform mode against the model
    task automatic runMode(input int md);
        doReset();
        wr(`TMR8_OFS_CMP_A, 8'h10 + 8'($urandom % 224));
        wr(`TMR8_OFS_CMP_B, 8'($urandom));
        wr(`TMR8_OFS_MASK, 8'h07);
        wr(`TMR8_OFS_COUNT, 8'h00);
        wr(`TMR8_OFS_CTRL_A, 8'(md % 4));
        wr(`TMR8_OFS_CTRL_B, 8'(md / 4 * 8 + 1));
        for (int i = 0; i < 520; i++) begin
            tick();
            if (i == 40) wr(`TMR8_OFS_CMP_B, 8'($urandom));
            if (i == 60) wr(`TMR8_OFS_CMP_A, 8'h10 + 8'($urandom % 224));
            rdchk(`TMR8_OFS_COUNT);
            rdchk(`TMR8_OFS_FLAGS);
            chk({29'h0, irqReq}, mFlags & mMask);
            if (mFlags != 0) wr(`TMR8_OFS_FLAGS, 8'(mFlags));
        end
        rdchk(`TMR8_OFS_CMP_B);
        $display("test mode %0d done", md);
    endtask

    initial begin
        errors = 0;
        num_checks = 0;
        rst = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h00000000;
        tickIn = 1'b0;
        intAck = 3'b000;
        portData = 2'b00;
        portDir = 2'b00;
        void'($urandom(32'hebd0));
        repeat (2) @(posedge clk_sys);
        rst <= 1'b0;
        mdlClear();
        chk({28'h0, pins}, 32'h3);
        apb(1'b1, 12'h01c, 8'hff, 1'b0);
        chk({31'h0, err}, 32'h1);
        for (int a = 0; a <= 'h1c; a += 4) rdchk(12'(a));
        wr(`TMR8_OFS_COUNT, 8'h42);
        repeat (3) tick();
        rdchk(`TMR8_OFS_COUNT);
        wr(`TMR8_OFS_CTRL_B, 8'h01);
        apb(1'b1, `TMR8_OFS_COUNT, 8'h20, 1'b1);
        mdlWrite(`TMR8_OFS_COUNT, 8'h20);
        rdchk(`TMR8_OFS_COUNT);
        wr(`TMR8_OFS_COUNT, 8'hfe);
        repeat (2) tick();
        rdchk(`TMR8_OFS_FLAGS);
        chk({29'h0, irqReq}, 32'h0);
        wr(`TMR8_OFS_FLAGS, 8'h00);
        wr(`TMR8_OFS_MASK, 8'h01);
        rdchk(`TMR8_OFS_FLAGS);
        chk({29'h0, irqReq}, 32'h1);
        @(posedge clk_sys);
        intAck <= 3'b001;
        @(posedge clk_sys);
        intAck <= 3'b000;
        mFlags = mFlags & ~1;
        rdchk(`TMR8_OFS_FLAGS);
        chk({29'h0, irqReq}, 32'h0);
        wr(`TMR8_OFS_CTRL_B, 8'h00);
        wr(`TMR8_OFS_CMP_A, 8'h30);
        wr(`TMR8_OFS_COUNT, 8'h30);
        wr(`TMR8_OFS_CTRL_B, 8'h01);
        repeat (2) tick();
        rdchk(`TMR8_OFS_FLAGS);
        wr(`TMR8_OFS_COUNT, 8'h2f);
        repeat (3) tick();
        rdchk(`TMR8_OFS_FLAGS);
        $display("test basic done");
        doReset();
        // output state preset by force before the pin turns output
        wr(`TMR8_OFS_CTRL_A, 8'h80);
        wr(`TMR8_OFS_CTRL_B, 8'h80);
        portDir <= 2'b01;
        portData <= 2'b10;
        repeat (3) @(posedge clk_sys);
        chk({28'h0, pins}, 32'ha);
        wr(`TMR8_OFS_COUNT, 8'h5a);
        for (int k = 1; k < 4; k++) begin
            wr(`TMR8_OFS_CTRL_A, 8'(k * 64));
            wr(`TMR8_OFS_CTRL_B, 8'h80);
            pinA(32'(mOcA));
        end
        rdchk(`TMR8_OFS_FLAGS);
        rdchk(`TMR8_OFS_COUNT);
        wr(`TMR8_OFS_CTRL_A, 8'hf0);
        wr(`TMR8_OFS_CTRL_B, 8'h40);
        repeat (4) @(posedge clk_sys);
        chk({28'h0, pins}, 32'he);
        wr(`TMR8_OFS_CTRL_A, 8'h00);
        wr(`TMR8_OFS_CMP_A, 8'h05);
        wr(`TMR8_OFS_COUNT, 8'h03);
        wr(`TMR8_OFS_CTRL_B, 8'h01);
        repeat (3) tick();
        wr(`TMR8_OFS_CTRL_A, 8'h40);
        pinA(32'h1);
        wr(`TMR8_OFS_COUNT, 8'h03);
        repeat (3) tick();
        pinA(32'h0);
        wr(`TMR8_OFS_CTRL_A, 8'hc0);
        wr(`TMR8_OFS_CTRL_B, 8'h80);
        wr(`TMR8_OFS_CTRL_A, 8'h43);
        wr(`TMR8_OFS_CTRL_B, 8'h80);
        pinA(32'h1);
        $display("test outputs done");
        foreach (modes[i]) runMode(modes[i]);
        report_and_stop();
    end
endmodule
